/* design/dcd_pkg.sv */
// Overview of operation
// - Queued issue: busy, set release flag if queue not ready, drop busy
// - Queued data moves, interrupt after last word
// - Release interrupt only when enabled, then accept commands
// - Listed opcodes map to one of five classes, all others to none (abort)
// - Listed opcodes and attribute reads are PIO in
// - Listed opcodes and log write are PIO out
// - Listed opcodes and other monitoring functions are non-data
// - C8, C9, CA, CB, 25, 35 are DMA
// - C7, 26, CC, 36, A2 are queued DMA
// - Alternate power opcodes run as their primaries
// - Recalibrate and seek decode upper digit only
// - Monitoring function chosen by feature register
// - Feature 5D/DD enables/disables release interrupt
// - Write cache, look-ahead and transfer mode features
// - Feature 44 selects 52, BB selects 4 ECC bytes
// - Power management, standby power-up and spin-up features
// - Acoustic, address offset and revert-default features
// - Act only when device-select bit matches
// - Addressing-mode bit selects CHS or LBA
// - Retry bit ignored, both codes decode alike
// - Power query loads FFh or 0 into count
// - Power query clears busy, fault, errors
// - Status register read clears pending interrupt
// - Invalid parameter aborts with error, abort, interrupt
// - Overlay function chosen by feature register
package dcd_pkg;
   localparam int unsigned AXI_ADDR_W = 8;
   // Register byte offsets
   localparam logic [7:0] OFS_FEATURE = 8'h00;
   localparam logic [7:0] OFS_COUNT = 8'h04;
   localparam logic [7:0] OFS_ADDRESS = 8'h08;
   localparam logic [7:0] OFS_DEV_HEAD = 8'h0c;
   localparam logic [7:0] OFS_COMMAND = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam logic [7:0] OFS_ERROR = 8'h18;
   localparam logic [7:0] OFS_SETTINGS = 8'h1c;
   localparam logic [7:0] OFS_QUEUE = 8'h20;
   // Field positions
   localparam int unsigned ST_BUSY_BIT = 7;
   localparam int unsigned ST_RDY_BIT = 6;
   localparam int unsigned ST_DF_BIT = 5;
   localparam int unsigned ST_DRQ_BIT = 3;
   localparam int unsigned ST_ERR_BIT = 0;
   localparam int unsigned ERR_ABT_BIT = 2;
   localparam int unsigned DH_DEV_BIT = 4;
   localparam int unsigned DH_LBA_BIT = 6;
   localparam int unsigned SET_WCACHE = 0;
   localparam int unsigned SET_LOOKAHEAD = 1;
   localparam int unsigned SET_REL_IRQ = 2;
   localparam int unsigned SET_ECC52 = 3;
   localparam int unsigned SET_APM = 4;
   localparam int unsigned SET_PUIS = 5;
   localparam int unsigned SET_AAM = 6;
   localparam int unsigned SET_OFFSET = 7;
   localparam int unsigned SET_REVERT = 8;
   localparam int unsigned SET_W = 9;
   // Reset values
   localparam logic [SET_W-1:0] RST_SETTINGS = 9'h103;
   localparam logic [7:0] RST_TASK = 8'h00;
   localparam logic [7:0] RST_XFER_MODE = 8'h00;
   // Power query answers
   localparam logic [7:0] PWR_ACTIVE = 8'hff;
   localparam logic [7:0] PWR_LOW = 8'h00;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // Opcodes steering decode
   localparam logic [7:0] OPC_SET_FEATURES = 8'hef;
   localparam logic [7:0] OPC_MONITOR = 8'hb0;
   localparam logic [7:0] OPC_OVERLAY = 8'hb1;
   localparam logic [7:0] OPC_POWER_CHECK = 8'he5;

   typedef enum logic [2:0]
   {
      CLS_NONE = 3'b000,
      CLS_PIO_IN = 3'b001,
      CLS_PIO_OUT = 3'b010,
      CLS_NONDATA = 3'b011,
      CLS_DMA = 3'b100,
      CLS_QUEUED = 3'b101
   } dcd_class_t;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_DECODE = 2'b01,
      ST_XFER = 2'b10
   } dcd_state_t;
endpackage

/* design/dcd_top.sv */
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module dcd_top
   import dcd_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // AXI4-Lite write address
   input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   // AXI4-Lite read address
   input wire logic [AXI_ADDR_W-1:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // Drive state
   input wire logic dev_num_i,
   input wire logic spindle_ready_i,
   input wire logic standby_i,
   input wire logic sleep_i,
   input wire logic drive_fault_i,
   input wire logic queue_ready_i,
   input wire logic xfer_done_i,
   // Command execution
   output logic busy_o,
   output logic data_request_o,
   output logic dma_request_o,
   output logic irq_o,
   output logic bus_release_o,
   output logic lba_mode_o,
   output logic exec_start_o,
   output logic spinup_req_o,
   output logic [2:0] proto_class_o,
   output logic [7:0] exec_opcode_o,
   output logic [27:0] target_addr_o
);

   dcd_state_t state_q;
   dcd_class_t class_q;
   dcd_class_t cls_w;
   logic aw_have_q, w_have_q, awready_q, wready_q, bvalid_q;
   logic arready_q, rvalid_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q, rd_data;
   logic rd_ok, wr_ok;
   logic [7:0] wr_ofs, rd_ofs;
   logic wr_fire, rd_fire, cmd_fire, status_rd, host_wr, irq_set;
   logic [7:0] feature_q, count_q, dev_head_q, opcode_q, xfer_mode_q;
   logic [23:0] addr_q;
   logic [SET_W-1:0] settings_q;
   logic busy_q, drq_q, dmarq_q, rel_q, err_q, abt_q, df_q, rdy_q, irq_q;
   logic exec_start_q, spinup_q;
   logic [7:0] status_w, error_w;
   logic is_power_check, is_features;

   // Alternate power codes collapse onto their primaries
   function automatic logic [7:0] canon(input logic [7:0] op);
      case (op)
         8'h98: canon = 8'he5;
         8'h97: canon = 8'he3;
         8'h95: canon = 8'he1;
         8'h96: canon = 8'he2;
         8'h94: canon = 8'he0;
         8'h99: canon = 8'he6;
         default: canon = op;
      endcase
   endfunction

   // Legal set-features values
   function automatic logic feat_ok(input logic [7:0] f);
      case (f)
         8'h02, 8'h03, 8'h05, 8'h06, 8'h07, 8'h09, 8'h42, 8'h44, 8'h55, 8'h5d,
         8'h66, 8'h82, 8'h85, 8'h86, 8'h89, 8'haa, 8'hbb, 8'hc2, 8'hcc,
         8'hdd: feat_ok = 1'b1;
         default: feat_ok = 1'b0;
      endcase
   endfunction

   // Opcode and subcommand to protocol class
   function automatic dcd_class_t class_of(input logic [7:0] op, input logic [7:0] f);
      casez (op)
         8'h1?, 8'h7?: class_of = CLS_NONDATA;
         8'hec, 8'h20, 8'h21, 8'h24, 8'hc4, 8'h29, 8'h22, 8'h23, 8'he4,
         8'h2f: class_of = CLS_PIO_IN;
         8'h30, 8'h31, 8'h34, 8'hc5, 8'h39, 8'h32, 8'h33, 8'he8, 8'h3f, 8'h50,
         8'hf1, 8'hf2, 8'hf4, 8'hf6: class_of = CLS_PIO_OUT;
         8'he5, 8'he7, 8'hea, 8'he3, 8'he1, 8'h91, 8'h00, 8'hf8, 8'h27, 8'h40,
         8'h41, 8'h42, 8'hf9, 8'h37, 8'hc6, 8'he6, 8'he2, 8'he0, 8'hf3, 8'hf5,
         8'h90: class_of = CLS_NONDATA;
         8'hef: class_of = feat_ok(f) ? CLS_NONDATA : CLS_NONE;
         8'hc8, 8'hc9, 8'hca, 8'hcb, 8'h25, 8'h35: class_of = CLS_DMA;
         8'hc7, 8'h26, 8'hcc, 8'h36, 8'ha2: class_of = CLS_QUEUED;
         8'hb0:
         begin
            case (f)
               8'hd0, 8'hd1: class_of = CLS_PIO_IN;
               8'hd6: class_of = CLS_PIO_OUT;
               8'hd2, 8'hd3, 8'hd4, 8'hd5, 8'hd8, 8'hd9, 8'hda,
               8'hdb: class_of = CLS_NONDATA;
               default: class_of = CLS_NONE;
            endcase
         end
         8'hb1:
         begin
            case (f)
               8'hc0, 8'hc1: class_of = CLS_NONDATA;
               8'hc2: class_of = CLS_PIO_IN;
               8'hc3: class_of = CLS_PIO_OUT;
               default: class_of = CLS_NONE;
            endcase
         end
         default: class_of = CLS_NONE;
      endcase
   endfunction

   assign cls_w = class_of(opcode_q, feature_q);
   assign is_power_check = (opcode_q == OPC_POWER_CHECK);
   assign is_features = (opcode_q == OPC_SET_FEATURES);

   // Write channel capture
   assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
   assign wr_ofs = {awaddr_q[7:2], 2'b00};
   assign host_wr = wr_fire && (state_q == ST_IDLE);
   assign cmd_fire = host_wr && (wr_ofs == OFS_COMMAND) && wstrb_q[0]
                     && (dev_head_q[DH_DEV_BIT] == dev_num_i);

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         aw_have_q <= 1'b0;
         awready_q <= 1'b0;
         awaddr_q <= 8'h00;
      end
      else if (s_axi_awvalid_i && awready_q)
      begin
         aw_have_q <= 1'b1;
         awready_q <= 1'b0;
         awaddr_q <= s_axi_awaddr_i;
      end
      else if (bvalid_q && s_axi_bready_i)
         aw_have_q <= 1'b0;
      else if (!aw_have_q && !bvalid_q)
         awready_q <= 1'b1;
   end

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         w_have_q <= 1'b0;
         wready_q <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end
      else if (s_axi_wvalid_i && wready_q)
      begin
         w_have_q <= 1'b1;
         wready_q <= 1'b0;
         wdata_q <= s_axi_wdata_i;
         wstrb_q <= s_axi_wstrb_i;
      end
      else if (bvalid_q && s_axi_bready_i)
         w_have_q <= 1'b0;
      else if (!w_have_q && !bvalid_q)
         wready_q <= 1'b1;
   end

   always_comb
   begin
      case (wr_ofs)
         OFS_FEATURE, OFS_COUNT, OFS_ADDRESS, OFS_DEV_HEAD, OFS_COMMAND, OFS_STATUS,
         OFS_ERROR, OFS_SETTINGS, OFS_QUEUE: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end
      else if (wr_fire)
      begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready_i)
         bvalid_q <= 1'b0;
   end

   // Read channel
   assign rd_fire = s_axi_arvalid_i && arready_q;
   assign rd_ofs = {s_axi_araddr_i[7:2], 2'b00};
   assign status_rd = rd_fire && (rd_ofs == OFS_STATUS);

   always_comb
   begin
      status_w = 8'h00;
      status_w[ST_BUSY_BIT] = busy_q;
      status_w[ST_RDY_BIT] = rdy_q;
      status_w[ST_DF_BIT] = df_q;
      status_w[ST_DRQ_BIT] = drq_q;
      status_w[ST_ERR_BIT] = err_q;
      error_w = 8'h00;
      error_w[ERR_ABT_BIT] = abt_q;
   end

   always_comb
   begin
      rd_ok = 1'b1;
      case (rd_ofs)
         OFS_FEATURE: rd_data = {24'h00_0000, feature_q};
         OFS_COUNT: rd_data = {24'h00_0000, count_q};
         OFS_ADDRESS: rd_data = {8'h00, addr_q};
         OFS_DEV_HEAD: rd_data = {24'h00_0000, dev_head_q};
         OFS_COMMAND: rd_data = {24'h00_0000, opcode_q};
         OFS_STATUS: rd_data = {24'h00_0000, status_w};
         OFS_ERROR: rd_data = {24'h00_0000, error_w};
         OFS_SETTINGS: rd_data = {8'h00, xfer_mode_q, 7'h00, settings_q};
         OFS_QUEUE: rd_data = {22'h00_0000, state_q, 1'b0, class_q, 3'h0, rel_q};
         default:
         begin
            rd_ok = 1'b0;
            rd_data = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= RESP_OKAY;
      end
      else if (rd_fire)
      begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rdata_q <= rd_data;
         rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid_q && s_axi_rready_i)
         rvalid_q <= 1'b0;
      else if (!rvalid_q)
         arready_q <= 1'b1;
   end

   // Task-file parameter registers, written only while idle
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         feature_q <= RST_TASK;
         dev_head_q <= RST_TASK;
      end
      else if (host_wr && wstrb_q[0])
      begin
         if (wr_ofs == OFS_FEATURE)
            feature_q <= wdata_q[7:0];
         if (wr_ofs == OFS_DEV_HEAD)
            dev_head_q <= wdata_q[7:0];
      end
   end

   genvar gb;
   generate
      for (gb = 0; gb < 3; gb++)
      begin : g_addr
         always_ff @(posedge ref_clk_i or posedge rst_i)
         begin
            if (rst_i)
               addr_q[gb*8 +: 8] <= RST_TASK;
            else if (host_wr && (wr_ofs == OFS_ADDRESS) && wstrb_q[gb])
               addr_q[gb*8 +: 8] <= wdata_q[gb*8 +: 8];
         end
      end
   endgenerate

   // Sector count: host writes it, power query answers in it
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         count_q <= RST_TASK;
      else if (state_q == ST_DECODE && is_power_check)
         count_q <= (spindle_ready_i && !standby_i && !sleep_i) ? PWR_ACTIVE : PWR_LOW;
      else if (host_wr && (wr_ofs == OFS_COUNT) && wstrb_q[0])
         count_q <= wdata_q[7:0];
   end

   // Command sequencer
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_q <= ST_IDLE;
         class_q <= CLS_NONE;
         opcode_q <= RST_TASK;
         busy_q <= 1'b0;
         drq_q <= 1'b0;
         dmarq_q <= 1'b0;
         rel_q <= 1'b0;
         err_q <= 1'b0;
         abt_q <= 1'b0;
      end
      else
      begin
         unique case (state_q)
            ST_IDLE:
            begin
               if (cmd_fire)
               begin
                  state_q <= ST_DECODE;
                  busy_q <= 1'b1;
                  opcode_q <= canon(wdata_q[7:0]);
                  err_q <= 1'b0;
                  abt_q <= 1'b0;
                  rel_q <= 1'b0;
               end
            end
            ST_DECODE:
            begin
               busy_q <= 1'b0;
               class_q <= cls_w;
               unique case (cls_w)
                  CLS_NONE:
                  begin
                     err_q <= 1'b1;
                     abt_q <= 1'b1;
                     state_q <= ST_IDLE;
                  end
                  CLS_NONDATA:
                     state_q <= ST_IDLE;
                  CLS_PIO_IN, CLS_PIO_OUT:
                  begin
                     drq_q <= 1'b1;
                     state_q <= ST_XFER;
                  end
                  CLS_DMA:
                  begin
                     dmarq_q <= 1'b1;
                     state_q <= ST_XFER;
                  end
                  CLS_QUEUED:
                  begin
                     rel_q <= !queue_ready_i;
                     dmarq_q <= queue_ready_i;
                     state_q <= queue_ready_i ? ST_XFER : ST_IDLE;
                  end
               endcase
            end
            ST_XFER:
            begin
               if (xfer_done_i)
               begin
                  drq_q <= 1'b0;
                  dmarq_q <= 1'b0;
                  state_q <= ST_IDLE;
               end
            end
            default:
               state_q <= ST_IDLE;
         endcase
      end
   end

   // Completion events raising the host interrupt
   always_comb
   begin
      irq_set = 1'b0;
      if (state_q == ST_DECODE)
      begin
         if (cls_w == CLS_NONE || cls_w == CLS_NONDATA)
            irq_set = 1'b1;
         else if (cls_w == CLS_QUEUED && !queue_ready_i)
            irq_set = settings_q[SET_REL_IRQ];
      end
      else if (state_q == ST_XFER && xfer_done_i)
         irq_set = 1'b1;
   end

   // Set beats the clear from a status read
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         irq_q <= 1'b0;
      else if (irq_set)
         irq_q <= 1'b1;
      else if (status_rd)
         irq_q <= 1'b0;
   end

   // Drive fault is sticky until a power query decodes while the fault input is low
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         df_q <= 1'b0;
         rdy_q <= 1'b0;
      end
      else
      begin
         rdy_q <= spindle_ready_i;
         if (drive_fault_i)
            df_q <= 1'b1;
         else if (state_q == ST_DECODE && is_power_check)
            df_q <= 1'b0;
      end
   end

   // Set-features effects
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         settings_q <= RST_SETTINGS;
         xfer_mode_q <= RST_XFER_MODE;
         spinup_q <= 1'b0;
      end
      else
      begin
         spinup_q <= 1'b0;
         if (state_q == ST_DECODE && is_features && cls_w == CLS_NONDATA)
         begin
            case (feature_q)
               8'h5d: settings_q[SET_REL_IRQ] <= 1'b1;
               8'hdd: settings_q[SET_REL_IRQ] <= 1'b0;
               8'h02: settings_q[SET_WCACHE] <= 1'b1;
               8'h82: settings_q[SET_WCACHE] <= 1'b0;
               8'h55: settings_q[SET_LOOKAHEAD] <= 1'b0;
               8'haa: settings_q[SET_LOOKAHEAD] <= 1'b1;
               8'h03: xfer_mode_q <= count_q;
               8'h44: settings_q[SET_ECC52] <= 1'b1;
               8'hbb: settings_q[SET_ECC52] <= 1'b0;
               8'h05: settings_q[SET_APM] <= 1'b1;
               8'h85: settings_q[SET_APM] <= 1'b0;
               8'h06: settings_q[SET_PUIS] <= 1'b1;
               8'h86: settings_q[SET_PUIS] <= 1'b0;
               8'h07: spinup_q <= 1'b1;
               8'h42: settings_q[SET_AAM] <= 1'b1;
               8'hc2: settings_q[SET_AAM] <= 1'b0;
               8'h09: settings_q[SET_OFFSET] <= 1'b1;
               8'h89: settings_q[SET_OFFSET] <= 1'b0;
               8'h66: settings_q[SET_REVERT] <= 1'b0;
               8'hcc: settings_q[SET_REVERT] <= 1'b1;
               default: spinup_q <= 1'b0;
            endcase
         end
      end
   end

   // Execution handoff
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         exec_start_q <= 1'b0;
         lba_mode_o <= 1'b0;
         target_addr_o <= 28'h000_0000;
      end
      else
      begin
         exec_start_q <= (state_q == ST_DECODE) && (cls_w != CLS_NONE);
         if (cmd_fire)
         begin
            lba_mode_o <= dev_head_q[DH_LBA_BIT];
            target_addr_o <= {dev_head_q[3:0], addr_q};
         end
      end
   end

   assign s_axi_awready_o = awready_q;
   assign s_axi_wready_o = wready_q;
   assign s_axi_bvalid_o = bvalid_q;
   assign s_axi_bresp_o = bresp_q;
   assign s_axi_arready_o = arready_q;
   assign s_axi_rvalid_o = rvalid_q;
   assign s_axi_rdata_o = rdata_q;
   assign s_axi_rresp_o = rresp_q;
   assign busy_o = busy_q;
   assign data_request_o = drq_q;
   assign dma_request_o = dmarq_q;
   assign irq_o = irq_q;
   assign bus_release_o = rel_q;
   assign exec_start_o = exec_start_q;
   assign spinup_req_o = spinup_q;
   assign proto_class_o = class_q;
   assign exec_opcode_o = opcode_q;

endmodule

/* dv/dcd_host_model.sv */
`timescale 1ns/1ps
module dcd_host_model
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Transfer control
   input wire logic req_i,
   input wire logic [3:0] lat_i,
   output logic done_o
);
   logic [3:0] cnt_q;
   // Waits lat_i+1 cycles of request, then pulses done once
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cnt_q <= 4'h0;
         done_o <= 1'b0;
      end
      else
      begin
         done_o <= req_i && !done_o && cnt_q == lat_i;
         cnt_q <= (req_i && !done_o) ? cnt_q + 4'h1 : 4'h0;
      end
   end
endmodule

/* dv/dcd_monitor.sv */
`timescale 1ns/1ps
module dcd_monitor
   import dcd_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Watched signals
   input wire logic busy_o, exec_start_o, irq_o, bus_release_o,
   input wire logic data_request_o, dma_request_o, xfer_done_i,
   input wire logic [2:0] proto_class_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   busy_one_a: assert property ($rose(busy_o) |=> !busy_o)
      else $error("busy held too long");
   busy_quiet_a: assert property (busy_o |-> !data_request_o && !dma_request_o)
      else $error("request during busy");
   start_valid_a: assert property (
      $fell(busy_o) && proto_class_o != CLS_NONE |-> exec_start_o)
      else $error("no start after decode");
   abort_irq_a: assert property (
      $fell(busy_o) && proto_class_o == CLS_NONE |-> irq_o && !exec_start_o)
      else $error("abort without interrupt");
   start_pulse_a: assert property (exec_start_o |=> !exec_start_o)
      else $error("start not a pulse");
   pio_class_a: assert property (
      data_request_o |-> proto_class_o inside {CLS_PIO_IN, CLS_PIO_OUT})
      else $error("data request wrong class");
   dma_class_a: assert property (
      dma_request_o |-> proto_class_o inside {CLS_DMA, CLS_QUEUED})
      else $error("dma request wrong class");
   release_idle_a: assert property (
      $fell(busy_o) && proto_class_o == CLS_QUEUED && bus_release_o |-> !dma_request_o)
      else $error("dma during release");
   done_irq_a: assert property (
      (data_request_o || dma_request_o) && xfer_done_i
      |=> !data_request_o && !dma_request_o && irq_o)
      else $error("completion not signalled");
endmodule

bind dcd_top dcd_monitor u_mon (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .busy_o(busy_o),
   .exec_start_o(exec_start_o), .irq_o(irq_o), .bus_release_o(bus_release_o),
   .data_request_o(data_request_o), .dma_request_o(dma_request_o),
   .xfer_done_i(xfer_done_i), .proto_class_o(proto_class_o));

/* dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top
   import dcd_pkg::*;
;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] aw_a = 8'h00, ar_a = 8'h00;
   logic [31:0] wd = 32'h0;
   logic [3:0] ws = 4'h0, lat = 4'h0;
   logic awv = 1'b0, wv = 1'b0, arv = 1'b0, stby = 1'b0, spin = 1'b1, qrdy = 1'b1;
   logic dnum = 1'b0, dflt = 1'b0;
   logic awr, wr, bv, arr, rv, done, busy, data_request_flag, dmq, irq, bus_release_flag, lba, sup;
   logic [27:0] tgt;
   logic [1:0] br, rr;
   logic [31:0] rd, d;
   logic [2:0] cls;
   logic [7:0] opc;
   int failures = 0, checks = 0, cyc = 0, sups = 0;

   always #50 ref_clk_i = ~ref_clk_i;

   // Counts spin-up pulses so a missing or repeated one shows
   always @(posedge ref_clk_i)
      if (sup) sups++;

   dcd_top uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .s_axi_awaddr_i(aw_a),
      .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws),
      .s_axi_wvalid_i(wv), .s_axi_wready_o(wr), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
      .s_axi_bready_i(1'b1), .s_axi_araddr_i(ar_a), .s_axi_arvalid_i(arv),
      .s_axi_arready_o(arr), .s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv),
      .s_axi_rready_i(1'b1), .dev_num_i(dnum), .spindle_ready_i(spin), .standby_i(stby),
      .sleep_i(1'b0), .drive_fault_i(dflt), .queue_ready_i(qrdy), .xfer_done_i(done),
      .busy_o(busy), .data_request_o(data_request_flag), .dma_request_o(dmq), .irq_o(irq),
      .bus_release_o(bus_release_flag), .lba_mode_o(lba), .exec_start_o(), .spinup_req_o(sup),
      .proto_class_o(cls), .exec_opcode_o(opc), .target_addr_o(tgt));
   dcd_host_model u_host (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_i(data_request_flag | dmq),
      .lat_i(lat), .done_o(done));

   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e)
      begin
         failures++;
         $display("unexpected %s exp %h seen %h", n, e, s);
      end
   endtask

   task automatic wrr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk_i);
      {aw_a, wd, ws} <= {a, v, 4'hf};
      {awv, wv} <= 2'b11;
      do
      begin
         @(posedge ref_clk_i);
         if (awr) awv <= 1'b0;
         if (wr) wv <= 1'b0;
      end
      while ((awv && !awr) || (wv && !wr));
      do @(posedge ref_clk_i); while (!bv);
   endtask

   task automatic rdr(input logic [7:0] a);
      @(posedge ref_clk_i);
      ar_a <= a;
      arv <= 1'b1;
      do @(posedge ref_clk_i); while (!arr);
      arv <= 1'b0;
      do @(posedge ref_clk_i); while (!rv);
      d = rd;
   endtask

   task automatic issue(input logic [7:0] o, input logic [7:0] f, input logic [7:0] dh);
      wrr(OFS_FEATURE, {24'h0, f});
      wrr(OFS_DEV_HEAD, {24'h0, dh});
      wrr(OFS_COMMAND, {24'h0, o});
      repeat (2) @(posedge ref_clk_i);
   endtask

   task automatic t_settings;
      rdr(OFS_SETTINGS);
      chk("settings reset", d[8:0], RST_SETTINGS);
      issue(8'hef, 8'h82, 8'h00);
      issue(8'hef, 8'h44, 8'h00);
      rdr(OFS_SETTINGS);
      chk("settings", d[8:0], (RST_SETTINGS & ~9'h001) | 9'h008);
      issue(8'hef, 8'h07, 8'h00);
      chk("spinup", sups, 1);
      rdr(8'h24);
      chk("unmapped", rr, RESP_SLVERR);
      rdr(OFS_STATUS);
      $display("settings test done");
   endtask

   task automatic t_classes;
      logic [23:0] tbl [20] = '{24'hec0001, 24'h240001, 24'h210001,
         24'h300002, 24'hf60002, 24'he50003, 24'h1f0003, 24'h7a0003,
         24'hc80004, 24'h350004, 24'hc70005, 24'ha20005,
         24'hb0d001, 24'hb0d602, 24'hb0d903, 24'hb1c201, 24'hb1c302,
         24'hefaa03, 24'hff0000, 24'hb07700};
      for (int i = 0; i < 20; i++)
      begin
         lat <= 4'(i);
         issue(tbl[i][23:16], tbl[i][15:8], {1'b0, i[0], 6'h00});
         chk("class", cls, tbl[i][7:0]);
         chk("lba", lba, i[0]);
         while (data_request_flag || dmq) @(posedge ref_clk_i);
         chk("irq", irq, 1'b1);
         rdr(OFS_STATUS);
         chk("err", d[ST_ERR_BIT], tbl[i][7:0] == 8'h00);
         chk("irq clear", irq, 1'b0);
      end
      $display("class test done");
   endtask

   task automatic t_power;
      dflt <= 1'b1;
      @(posedge ref_clk_i);
      dflt <= 1'b0;
      rdr(OFS_STATUS);
      chk("fault", d[ST_DF_BIT], 1'b1);
      issue(8'h98, 8'h00, 8'h00);
      chk("opcode", opc, 8'he5);
      rdr(OFS_COUNT);
      chk("count", d[7:0], PWR_ACTIVE);
      rdr(OFS_STATUS);
      chk("status", d[7:5], 3'b010);
      spin <= 1'b0;
      issue(8'he5, 8'h00, 8'h00);
      rdr(OFS_COUNT);
      chk("count", d[7:0], PWR_LOW);
      {spin, stby} <= 2'b11;
      issue(8'he5, 8'h00, 8'h00);
      rdr(OFS_COUNT);
      chk("count", d[7:0], PWR_LOW);
      stby <= 1'b0;
      rdr(OFS_STATUS);
      $display("power test done");
   endtask

   task automatic t_release;
      qrdy <= 1'b0;
      issue(8'hc7, 8'h00, 8'h00);
      chk("release", {bus_release_flag, irq, dmq}, 3'b100);
      issue(8'hef, 8'h5d, 8'h00);
      rdr(OFS_STATUS);
      issue(8'hcc, 8'h00, 8'h00);
      chk("release irq", irq, 1'b1);
      issue(8'hef, 8'hdd, 8'h00);
      rdr(OFS_STATUS);
      issue(8'h36, 8'h00, 8'h00);
      chk("release irq", irq, 1'b0);
      qrdy <= 1'b1;
      issue(8'hec, 8'h00, 8'h10);
      chk("other drive", {opc, data_request_flag, busy}, {8'h36, 2'b00});
      dnum <= 1'b1;
      wrr(OFS_ADDRESS, 32'h0012_3456);
      issue(8'h20, 8'h00, 8'h5b);
      chk("target", tgt, 28'hb12_3456);
      chk("this drive", {lba, data_request_flag}, 2'b11);
      while (data_request_flag) @(posedge ref_clk_i);
      $display("release test done");
   endtask

   task automatic report_and_stop;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   always @(posedge ref_clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         failures++;
         report_and_stop;
      end
   end

   initial
   begin
      repeat (4) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      t_settings;
      t_classes;
      t_power;
      t_release;
      report_and_stop;
   end
endmodule
